/* File: logic/srsw_pkg.sv */
// constants, field layout and types of the serial radio setup word
`default_nettype none
package srsw_pkg;
    // word length and shift counter
    localparam int         WORD_BITS  = 80;
    localparam logic [6:0] LAST_INDEX = 7'h4f;

    // timing: a shift that stalls longer than the idle gap drops the partial word
    localparam int CLK_PERIOD_NS = 20;
    localparam int IDLE_GAP_NS   = 20000;
    localparam int IDLE_CYCLES   = IDLE_GAP_NS / CLK_PERIOD_NS;

    // applied word after reset: everything powered down, all dividers zero
    localparam logic [79:0] APPLIED_RESET = 80'h0;

    // field layout; position p(k) lands in word bit 80-k
    localparam int PRE_W        = 6;
    localparam int PRE_B_LSB    = 74;
    localparam int PRE_A_LSB    = 68;
    localparam int MAIN_W       = 12;
    localparam int MAIN_B_LSB   = 56;
    localparam int MAIN_A_LSB   = 44;
    localparam int REF_W        = 10;
    localparam int REF_B_LSB    = 34;
    localparam int REF_A_LSB    = 24;
    localparam int RXCAP_BIT    = 23;
    localparam int LEVEL_W      = 3;
    localparam int LEVEL_LSB    = 20;
    localparam int GAIN_BIT     = 19;
    localparam int BYPASS_BIT   = 18;
    localparam int LOCK_W       = 7;
    localparam int LOCK_LSB     = 11;
    localparam int PUMP_HI_BIT  = 10;
    localparam int PUMP_LO_BIT  = 9;
    localparam int CORNER_W     = 2;
    localparam int CORNER_LSB   = 7;
    localparam int TEST_W       = 3;
    localparam int TEST_LSB     = 4;
    localparam int SCHEME_HI_BIT = 3;
    localparam int SCHEME_LO_BIT = 2;
    localparam int AUX_BIT      = 1;
    localparam int POWER_BIT    = 0;

    // prefilter corner codes {hi, lo}
    localparam logic [1:0] CORNER_10K  = 2'h0;
    localparam logic [1:0] CORNER_30K  = 2'h1;
    localparam logic [1:0] CORNER_60K  = 2'h2;
    localparam logic [1:0] CORNER_200K = 2'h3;

    // shift framing states
    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } srsw_state_t;

    // one-hot corner select, bit n set for code n
    function automatic logic [3:0] srsw_corner_onehot(input logic [1:0] code);
        srsw_corner_onehot = 4'h1 << code;
    endfunction
endpackage
`default_nettype wire

/* File: logic/srsw_sync.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module srsw_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // srsw_sync
`default_nettype wire

/* File: logic/srsw_setup_word.sv */
// serial setup word: two-line shift register, word apply and field outputs
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - whole setup held in one 80-bit word
// - only serial clock and data lines exist
// - first bit is p1, last is p80
// - p1-p6 and p7-p12: prescaler counts
// - p13-p24 and p25-p36: main dividers
// - p37-p46 and p47-p56: reference dividers
// - p72-p73 corner; code 10 is 60 kHz
// - test select, scheme, aux, power bits
// - word sets dividers and section power
// - bypass bit set routes around front amp
// - level zero lowest, all ones highest
// - lock field zero highest, ones lowest
// - cap select set uses external capacitor
module srsw_setup_word #(
    parameter int IDLE_CYCLES = srsw_pkg::IDLE_CYCLES
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          serial_shift_clock,
    input  wire logic                          serial_setup_input,
    output logic [srsw_pkg::PRE_W-1:0]         prescaler_count_b,
    output logic [srsw_pkg::PRE_W-1:0]         prescaler_count_a,
    output logic [srsw_pkg::MAIN_W-1:0]        main_divider_b,
    output logic [srsw_pkg::MAIN_W-1:0]        main_divider_a,
    output logic [srsw_pkg::REF_W-1:0]         reference_divider_b,
    output logic [srsw_pkg::REF_W-1:0]         reference_divider_a,
    output logic                               rx_data_cap_select,
    output logic                               tx_level_bit2,
    output logic                               tx_level_bit1,
    output logic                               tx_level_bit0,
    output logic                               preamp_gain_select,
    output logic                               front_amp_bypass,
    output logic [srsw_pkg::LOCK_W-1:0]        lock_threshold_field,
    output logic                               pump_current_hi,
    output logic                               pump_current_lo,
    output logic                               prefilter_corner_hi,
    output logic                               prefilter_corner_lo,
    output logic [3:0]                         prefilter_corner_sel,
    output logic [srsw_pkg::TEST_W-1:0]        test_output_select,
    output logic                               tx_scheme_select_hi,
    output logic                               tx_scheme_select_lo,
    output logic                               aux_control_bit,
    output logic                               block_power_enable,
    output logic                               word_applied
);
    localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES - 1);

    logic [1:0]                     pins_sync;
    logic                           sclk_s;
    logic                           sdata_s;
    logic                           sclk_prev;
    logic                           sclk_rise;
    logic [79:0]                    shift_word;
    logic [79:0]                    next_shift;
    logic [6:0]                     bit_count;
    logic [6:0]                     next_count;
    srsw_pkg::srsw_state_t          state;
    srsw_pkg::srsw_state_t          next_state;
    logic [IDLE_W-1:0]              idle_count;
    logic [IDLE_W-1:0]              next_idle;
    logic [79:0]                    applied;
    logic [79:0]                    next_applied;
    logic [3:0]                     next_corner;
    logic                           next_loaded;

    // two lines only
    // both pins cross into clk through the same two-flop path
    srsw_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({serial_shift_clock, serial_setup_input}),
        .sync_out (pins_sync)
    );
    assign sclk_s  = pins_sync[1];
    assign sdata_s = pins_sync[0];

    // rising edge detect
    // edge found on the second stage; data and clock share the same latency
    assign sclk_rise = sclk_s & ~sclk_prev;

    // next values for shifting, framing and the applied word
    always_comb
    begin
        next_shift   = shift_word;
        next_count   = bit_count;
        next_state   = state;
        next_idle    = idle_count;
        next_applied = applied;
        next_corner  = prefilter_corner_sel;
        next_loaded  = 1'b0;
        if (sclk_rise)
        begin
            // msb first shifting
            // earliest bit walks up to word bit 79, which is p1
            next_shift = {shift_word[78:0], sdata_s};
            next_idle  = '0;
            if (bit_count == srsw_pkg::LAST_INDEX)
            begin
                // apply full word
                // controls change only here, never mid-word
                next_applied = next_shift;
                next_corner  = srsw_pkg::srsw_corner_onehot(
                    next_shift[srsw_pkg::CORNER_LSB +: srsw_pkg::CORNER_W]);
                next_loaded  = 1'b1;
                next_count   = '0;
                next_state   = srsw_pkg::ST_IDLE;
            end
            else
            begin
                next_count = 7'(bit_count + 7'h1);
                next_state = srsw_pkg::ST_SHIFT;
            end
        end
        else
        begin
            // no select line, so a stalled partial word is dropped to regain framing
            case (state)
                srsw_pkg::ST_IDLE:
                begin
                    next_idle = '0;
                end
                srsw_pkg::ST_SHIFT:
                begin
                    if (idle_count == IDLE_LAST)
                    begin
                        next_count = '0;
                        next_idle  = '0;
                        next_state = srsw_pkg::ST_IDLE;
                    end
                    else
                    begin
                        next_idle = IDLE_W'(idle_count + 1'b1);
                    end
                end
                default:
                begin
                    next_state = srsw_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // register stage for all state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_prev            <= 1'b0;
            shift_word           <= '0;
            bit_count            <= '0;
            state                <= srsw_pkg::ST_IDLE;
            idle_count           <= '0;
            applied              <= srsw_pkg::APPLIED_RESET;
            prefilter_corner_sel <= srsw_pkg::srsw_corner_onehot(srsw_pkg::CORNER_10K);
            word_applied         <= 1'b0;
        end
        else
        begin
            sclk_prev            <= sclk_s;
            shift_word           <= next_shift;
            bit_count            <= next_count;
            state                <= next_state;
            idle_count           <= next_idle;
            applied              <= next_applied;
            prefilter_corner_sel <= next_corner;
            word_applied         <= next_loaded;
        end
    end

    assign prescaler_count_b   = applied[srsw_pkg::PRE_B_LSB +: srsw_pkg::PRE_W];
    assign prescaler_count_a   = applied[srsw_pkg::PRE_A_LSB +: srsw_pkg::PRE_W];
    assign main_divider_b      = applied[srsw_pkg::MAIN_B_LSB +: srsw_pkg::MAIN_W];
    assign main_divider_a      = applied[srsw_pkg::MAIN_A_LSB +: srsw_pkg::MAIN_W];
    assign reference_divider_b = applied[srsw_pkg::REF_B_LSB +: srsw_pkg::REF_W];
    assign reference_divider_a = applied[srsw_pkg::REF_A_LSB +: srsw_pkg::REF_W];
    assign rx_data_cap_select  = applied[srsw_pkg::RXCAP_BIT];
    // level code, plain binary so zero is lowest power
    assign tx_level_bit2       = applied[srsw_pkg::LEVEL_LSB + 2];
    assign tx_level_bit1       = applied[srsw_pkg::LEVEL_LSB + 1];
    assign tx_level_bit0       = applied[srsw_pkg::LEVEL_LSB];
    assign preamp_gain_select  = applied[srsw_pkg::GAIN_BIT];
    assign front_amp_bypass    = applied[srsw_pkg::BYPASS_BIT];
    // lock field kept uninverted, zero means highest
    assign lock_threshold_field = applied[srsw_pkg::LOCK_LSB +: srsw_pkg::LOCK_W];
    assign pump_current_hi     = applied[srsw_pkg::PUMP_HI_BIT];
    assign pump_current_lo     = applied[srsw_pkg::PUMP_LO_BIT];
    assign prefilter_corner_hi = applied[srsw_pkg::CORNER_LSB + 1];
    assign prefilter_corner_lo = applied[srsw_pkg::CORNER_LSB];
    // test, scheme, aux and power bits; power drives sections
    assign test_output_select  = applied[srsw_pkg::TEST_LSB +: srsw_pkg::TEST_W];
    assign tx_scheme_select_hi = applied[srsw_pkg::SCHEME_HI_BIT];
    assign tx_scheme_select_lo = applied[srsw_pkg::SCHEME_LO_BIT];
    assign aux_control_bit     = applied[srsw_pkg::AUX_BIT];
    assign block_power_enable  = applied[srsw_pkg::POWER_BIT];

    // checks on the shift path and the applied word
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_shift_takes_data: assert property (
        sclk_rise |=> shift_word[0] == $past(sdata_s))
        else $error("shifted bit differs from sampled data");
    a_count_wraps_last: assert property (
        sclk_rise && bit_count == 7'h4f |=> bit_count == 7'h0 && word_applied)
        else $error("counter did not wrap after bit 80");
    a_hold_midword: assert property (
        !(sclk_rise && bit_count == 7'h4f) |=> $stable(applied) && !word_applied)
        else $error("controls changed before a full word");
    a_apply_msb_first: assert property (
        sclk_rise && bit_count == 7'h4f |=>
        applied == {$past(shift_word[78:0]), $past(sdata_s)})
        else $error("applied word not in shift order");
    a_first_bit_p1: assert property (
        word_applied |-> prescaler_count_b[5] == $past(shift_word[78]))
        else $error("first shifted bit not at p1");
    a_prescaler_field: assert property (
        word_applied |-> prescaler_count_a == $past(shift_word[72:67]))
        else $error("prescaler a field misplaced");
    a_main_field: assert property (
        word_applied |-> main_divider_a == $past(shift_word[54:43]))
        else $error("main divider a field misplaced");
    a_ref_field: assert property (
        word_applied |-> reference_divider_b == $past(shift_word[42:33]))
        else $error("reference divider b field misplaced");
    a_corner_sixty: assert property (
        prefilter_corner_hi && !prefilter_corner_lo |-> prefilter_corner_sel == 4'h4)
        else $error("corner code 10 not decoded as 60 kHz");
    a_power_last_bit: assert property (
        word_applied |-> block_power_enable == $past(sdata_s))
        else $error("power bit not taken from bit 80");
    a_idle_drop: assert property (
        state == srsw_pkg::ST_SHIFT && idle_count == IDLE_LAST && !sclk_rise
        |=> bit_count == 7'h0 && $stable(applied))
        else $error("stalled partial word not dropped");

    c_word_applied: cover property (word_applied);
    c_idle_drop: cover property (
        state == srsw_pkg::ST_SHIFT && idle_count == IDLE_LAST && !sclk_rise);
    c_corner_sixty: cover property (word_applied && prefilter_corner_sel == 4'h4);
    c_bypass_on: cover property (word_applied && front_amp_bypass);
endmodule // srsw_setup_word
`default_nettype wire

/* File: test/srsw_host_model.sv */
// host model: drives the two-line setup bus, one word or a cut-short word
`timescale 1ns/1ps
`default_nettype none
module srsw_host_model (
    input  wire logic clk,
    output logic      serial_shift_clock,
    output logic      serial_setup_input
);
    // clock low and data 0 at time zero; no pull on the data line
    initial
    begin
        serial_shift_clock = 1'b0;
        serial_setup_input = 1'b0;
    end

    // sends the first n bits of w; 160 ns bit period, 80 ns each phase
    task automatic send_bits(input logic [79:0] w, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            @(posedge clk);
            #1;
            serial_shift_clock = 1'b0;
            serial_setup_input = w[79 - i];
            repeat (4) @(posedge clk);
            #1;
            serial_shift_clock = 1'b1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        #1;
        serial_shift_clock = 1'b0;
        // released data shows the inverse, so a stale value cannot pass
        serial_setup_input = ~serial_setup_input;
    endtask
endmodule // srsw_host_model
`default_nettype wire

/* File: test/tb_serial_radio_setup_word.sv */
// self-checking bench for the serial setup word
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin samples_checked++; if (12'(g) !== 12'(e)) begin \
    error_cnt++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_serial_radio_setup_word;
    localparam logic [79:0] W_A = 80'h5a3c_96e1_0f7b_c248_d61f;
    localparam logic [79:0] W_B = ~W_A;
    logic clk, rst_n, word_applied, cap, l2, l1, l0, gain, byp, ph, pl, fh, fl;
    logic sh, sl, aux, pwr;
    logic [5:0]  pb, pa;
    logic [11:0] mb, ma;
    logic [9:0]  rb, ra;
    logic [6:0]  lock;
    logic [3:0]  corner_sel;
    logic [2:0]  tsel;
    wire         sck, sdi;
    int          error_cnt, samples_checked, cyc, applied_cnt, base;
    logic [3:0]  corner_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

    srsw_host_model host (.clk(clk), .serial_shift_clock(sck), .serial_setup_input(sdi));

    // short idle gap keeps the dropped-word test quick
    srsw_setup_word #(.IDLE_CYCLES(20)) uut (
        .clk(clk), .rst_n(rst_n), .serial_shift_clock(sck), .serial_setup_input(sdi),
        .prescaler_count_b(pb), .prescaler_count_a(pa), .main_divider_b(mb),
        .main_divider_a(ma), .reference_divider_b(rb), .reference_divider_a(ra),
        .rx_data_cap_select(cap), .tx_level_bit2(l2), .tx_level_bit1(l1),
        .tx_level_bit0(l0), .preamp_gain_select(gain), .front_amp_bypass(byp),
        .lock_threshold_field(lock), .pump_current_hi(ph), .pump_current_lo(pl),
        .prefilter_corner_hi(fh), .prefilter_corner_lo(fl),
        .prefilter_corner_sel(corner_sel), .test_output_select(tsel),
        .tx_scheme_select_hi(sh), .tx_scheme_select_lo(sl), .aux_control_bit(aux),
        .block_power_enable(pwr), .word_applied(word_applied));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard; a full run needs about 6500 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t timeout", $time);
            end_sim();
        end
    end

    // pulses counted per edge, so a stuck-high flag shows as extra counts
    always @(posedge clk)
        if (word_applied === 1'b1) applied_cnt++;

    // bits p..p+wd-1 of a word; p(k) sits at bit 80-k
    function automatic logic [11:0] fld(input logic [79:0] w, input int p, input int wd);
        fld = 12'((w >> (81 - p - wd)) & ((80'h1 << wd) - 80'h1));
    endfunction

    task automatic check_word(input logic [79:0] w);
        `CHK(pb, fld(w, 1, 6), "prescaler b")
        `CHK(pa, fld(w, 7, 6), "prescaler a")
        `CHK(mb, fld(w, 13, 12), "main b")
        `CHK(ma, fld(w, 25, 12), "main a")
        `CHK(rb, fld(w, 37, 10), "reference b")
        `CHK(ra, fld(w, 47, 10), "reference a")
        `CHK(cap, fld(w, 57, 1), "cap select")
        `CHK({l2, l1, l0}, fld(w, 58, 3), "level")
        `CHK(gain, fld(w, 61, 1), "gain")
        `CHK(byp, fld(w, 62, 1), "bypass")
        `CHK(lock, fld(w, 63, 7), "lock field")
        `CHK({ph, pl}, fld(w, 70, 2), "pump")
        `CHK({fh, fl}, fld(w, 72, 2), "corner")
        `CHK(corner_sel, corner_tab[fld(w, 72, 2)], "corner decode")
        `CHK(tsel, fld(w, 74, 3), "test select")
        `CHK({sh, sl}, fld(w, 77, 2), "scheme")
        `CHK(aux, fld(w, 79, 1), "aux")
        `CHK(pwr, fld(w, 80, 1), "power")
    endtask

    task automatic send(input logic [79:0] w, input int n);
        host.send_bits(w, n);
        repeat (6) @(posedge clk);
        #1;
    endtask

    // reset held 10 cycles; applied word must be all zero afterwards
    task automatic t_reset();
        // base taken before reset so a pulse in or right after reset is seen
        base = applied_cnt;
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check_word(80'h0);
        `CHK(applied_cnt, base, "pulse during reset")
    endtask

    task automatic t_full_word();
        base = applied_cnt;
        send(W_A, 80);
        `CHK(applied_cnt, base + 1, "one pulse per word")
        check_word(W_A);
    endtask

    // 79 bits then a stall: nothing applied, next word lands aligned
    task automatic t_partial_drop();
        base = applied_cnt;
        send(W_B, 79);
        repeat (40) @(posedge clk);
        `CHK(applied_cnt, base, "partial applied")
        check_word(W_A);
        send(W_B, 80);
        `CHK(applied_cnt, base + 1, "word after drop")
        check_word(W_B);
    endtask

    // every corner code, with level codes 0 and 7 among them
    task automatic t_corner_codes();
        logic [79:0] w;
        int          c;
        for (c = 0; c < 4; c++)
        begin
            w = (c % 2 == 0) ? W_A : W_B;
            w[8:7] = 2'(c);
            w[22:20] = (c < 2) ? 3'h0 : 3'h7;
            base = applied_cnt;
            send(w, 80);
            `CHK(applied_cnt, base + 1, "corner word pulse")
            check_word(w);
        end
    endtask

    task automatic t_back_to_back();
        base = applied_cnt;
        host.send_bits(W_A, 80);
        send(W_B, 80);
        `CHK(applied_cnt, base + 2, "two words")
        check_word(W_B);
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        rst_n = 1'b0;
        t_reset();
        t_full_word();
        t_partial_drop();
        t_corner_codes();
        t_back_to_back();
        t_reset();
        t_full_word();
        end_sim();
    end
endmodule // tb_serial_radio_setup_word
`default_nettype wire
